// ---- common/rio_pin_defs.vh ----
`ifndef RIO_PIN_DEFS_VH
`define RIO_PIN_DEFS_VH

// register indices on the plain register port
`define RIO_REG_DRIVE_SEL 4'h0
`define RIO_REG_TX_TRIG 4'h1
`define RIO_REG_PORT_A 4'h2
`define RIO_REG_PORT_B 4'h3
`define RIO_REG_PORT_C 4'h4
`define RIO_REG_PORT_D 4'h5
`define RIO_REG_FLAG 4'h6
`define RIO_REG_STRAPS 4'h8
`define RIO_REG_NODE_ID 4'h9
`define RIO_REG_PIN_C 4'hA
`define RIO_REG_PIN_D 4'hB
`define RIO_REG_TRIG_STAT 4'hC

// drive-select field positions in RIO_REG_DRIVE_SEL
`define RIO_DSEL_A_BIT 0
`define RIO_DSEL_B_BIT 1
`define RIO_DSEL_C_BIT 2

// strap status field positions in RIO_REG_STRAPS
`define RIO_STRAP_DIR_LSB 0
`define RIO_STRAP_PAGE_BIT 3

// trigger status field positions in RIO_REG_TRIG_STAT
`define RIO_TSTAT_EN1_BIT 0
`define RIO_TSTAT_EN2_BIT 1
`define RIO_TSTAT_ACT1_BIT 2
`define RIO_TSTAT_ACT2_BIT 3

// reset values: open-drain on all three drive selects
`define RIO_DRIVE_SEL_RST 3'h7
`define RIO_TX_TRIG_RST 4'h0
`define RIO_PORT_RST 8'h00

// transmit-trigger codes that turn on the external trigger inputs
`define RIO_TXTRG_EXT_A 4'h6
`define RIO_TXTRG_EXT_B 4'h7

`endif

// ---- hw/rio_pin_cfg.v ----
// Behaviour
// - First output-only port: push-pull if its drive select is 0, open-drain if 1 (reset).
// - Second output-only port: push-pull if its drive select is 0, open-drain if 1 (reset).
// - Third port is input while the first direction strap is low and output while it is high.
// - Third port as output: push-pull if its drive select is 0, open-drain if 1 (reset).
// - The third port's strap and drive select apply to all eight of its lines.
// - Third port bit 0 is trigger input one if strap one is low and the select is 6h or 7h.
// - Fourth port bit 0 is trigger input two if strap one is low, two high, select 6h or 7h.
// - Fourth port bits 0 to 3 are inputs if strap two is low, outputs if it is high.
// - With the third strap high, fourth port bit 4 becomes flag output bit 0.
// - The 4-bit node identifier is strapped on fourth port bits 0 to 3, bit 0 to bit 0.
// - The page-size selection is strapped on fourth port bit 4.
// - The block is in hardware reset while the active-low reset input is low.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rio_pin_defs.vh"

module rio_pin_cfg #(
  parameter PORT_W = 8,
  parameter PD_W = 5,
  parameter ID_W = 4
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_arst_n,
  // register port
  input wire [3:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  // direction straps, sampled during reset only
  input wire [2:0] i_direction_strap,
  // first output-only port
  output reg [PORT_W-1:0] o_out_port_one_lines,
  output reg [PORT_W-1:0] o_out_port_one_lines_oe,
  // second output-only port
  output reg [PORT_W-1:0] o_out_port_two_lines,
  output reg [PORT_W-1:0] o_out_port_two_lines_oe,
  // third port, two-way
  input wire [PORT_W-1:0] i_bidir_port_three,
  output reg [PORT_W-1:0] o_bidir_port_three,
  output reg [PORT_W-1:0] o_bidir_port_three_oe,
  // fourth port bits 0 to 4, two-way
  input wire [PD_W-1:0] i_bidir_port_four,
  output reg [PD_W-1:0] o_bidir_port_four,
  output reg [PD_W-1:0] o_bidir_port_four_oe,
  // trigger and strap results
  output reg o_ext_trigger_first,
  output reg o_ext_trigger_second,
  output reg [ID_W-1:0] o_node_id,
  output reg o_page_size_strap
);

  // pin drive: returns {oe, out}; open-drain only pulls low
  function [2*PORT_W-1:0] pin_drive;
    input [PORT_W-1:0] data;
    input od;
    input [PORT_W-1:0] en;
    reg [PORT_W-1:0] oe;
    reg [PORT_W-1:0] val;
    begin
      val = od ? {PORT_W{1'b0}} : data;
      oe = od ? (en & ~data) : en;
      pin_drive = {oe, val};
    end
  endfunction

  // reset release through two flip-flops
  reg rst_meta_r;
  reg rst_n_r;

  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // straps: plain flops loaded while reset is held
  reg [2:0] dir_strap_r;
  reg [ID_W-1:0] node_id_r;
  reg page_size_r;

  always @(posedge i_clk_sys) begin
    if (!rst_n_r) begin
      dir_strap_r <= i_direction_strap;
      node_id_r <= i_bidir_port_four[ID_W-1:0];
      page_size_r <= i_bidir_port_four[ID_W];
    end
  end

  wire dir_first = dir_strap_r[0];
  wire dir_second = dir_strap_r[1];
  wire dir_third = dir_strap_r[2];

  // software registers
  reg [2:0] drive_sel_r;
  reg [3:0] tx_trig_r;
  reg [PORT_W-1:0] port_a_r;
  reg [PORT_W-1:0] port_b_r;
  reg [PORT_W-1:0] port_c_r;
  reg [PD_W-1:0] port_d_r;
  reg flag_r;

  always @(posedge i_clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      drive_sel_r <= `RIO_DRIVE_SEL_RST;
      tx_trig_r <= `RIO_TX_TRIG_RST;
      port_a_r <= `RIO_PORT_RST;
      port_b_r <= `RIO_PORT_RST;
      port_c_r <= `RIO_PORT_RST;
      port_d_r <= {PD_W{1'b0}};
      flag_r <= 1'b0;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `RIO_REG_DRIVE_SEL: begin
          drive_sel_r <= i_reg_wdata[2:0];
        end
        `RIO_REG_TX_TRIG: begin
          tx_trig_r <= i_reg_wdata[3:0];
        end
        `RIO_REG_PORT_A: begin
          port_a_r <= i_reg_wdata;
        end
        `RIO_REG_PORT_B: begin
          port_b_r <= i_reg_wdata;
        end
        `RIO_REG_PORT_C: begin
          port_c_r <= i_reg_wdata;
        end
        `RIO_REG_PORT_D: begin
          port_d_r <= i_reg_wdata[PD_W-1:0];
        end
        `RIO_REG_FLAG: begin
          flag_r <= i_reg_wdata[0];
        end
        default: begin
        end
      endcase
    end
  end

  // pin function selection
  wire ext_sel = (tx_trig_r == `RIO_TXTRG_EXT_A) || (tx_trig_r == `RIO_TXTRG_EXT_B);
  wire trig1_en = !dir_first && ext_sel;
  wire trig2_en = !dir_first && dir_second && ext_sel;
  wire c_out = dir_first;
  wire d_out = dir_second;
  wire flag_mode = dir_third;

  reg [2*PORT_W-1:0] a_nxt;
  reg [2*PORT_W-1:0] b_nxt;
  reg [2*PORT_W-1:0] c_nxt;
  reg [PD_W-1:0] d_nxt;
  reg [PD_W-1:0] d_oe_nxt;

  always @* begin
    a_nxt = pin_drive(port_a_r, drive_sel_r[`RIO_DSEL_A_BIT], {PORT_W{1'b1}});
    b_nxt = pin_drive(port_b_r, drive_sel_r[`RIO_DSEL_B_BIT], {PORT_W{1'b1}});
    // one strap and one drive select span the whole port
    c_nxt = pin_drive(port_c_r, drive_sel_r[`RIO_DSEL_C_BIT], {PORT_W{c_out}});
    d_nxt = port_d_r;
    d_oe_nxt = {PD_W{d_out}};
    if (trig2_en) begin
      d_oe_nxt[0] = 1'b0;
    end
    if (flag_mode) begin
      d_nxt[PD_W-1] = flag_r;
      d_oe_nxt[PD_W-1] = 1'b1;
    end
  end

  // pin and result outputs, quiet while reset is held
  always @(posedge i_clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_out_port_one_lines <= {PORT_W{1'b0}};
      o_out_port_one_lines_oe <= {PORT_W{1'b0}};
      o_out_port_two_lines <= {PORT_W{1'b0}};
      o_out_port_two_lines_oe <= {PORT_W{1'b0}};
      o_bidir_port_three <= {PORT_W{1'b0}};
      o_bidir_port_three_oe <= {PORT_W{1'b0}};
      o_bidir_port_four <= {PD_W{1'b0}};
      o_bidir_port_four_oe <= {PD_W{1'b0}};
      o_ext_trigger_first <= 1'b0;
      o_ext_trigger_second <= 1'b0;
      o_node_id <= {ID_W{1'b0}};
      o_page_size_strap <= 1'b0;
    end else begin
      o_out_port_one_lines <= a_nxt[PORT_W-1:0];
      o_out_port_one_lines_oe <= a_nxt[2*PORT_W-1:PORT_W];
      o_out_port_two_lines <= b_nxt[PORT_W-1:0];
      o_out_port_two_lines_oe <= b_nxt[2*PORT_W-1:PORT_W];
      o_bidir_port_three <= c_nxt[PORT_W-1:0];
      o_bidir_port_three_oe <= c_nxt[2*PORT_W-1:PORT_W];
      o_bidir_port_four <= d_nxt;
      o_bidir_port_four_oe <= d_oe_nxt;
      // trigger pins are active low; outputs are active high
      o_ext_trigger_first <= trig1_en && !i_bidir_port_three[0];
      o_ext_trigger_second <= trig2_en && !i_bidir_port_four[0];
      o_node_id <= node_id_r;
      o_page_size_strap <= page_size_r;
    end
  end

  // register read, data in the following cycle only
  reg [7:0] rdata_nxt;

  always @* begin
    rdata_nxt = 8'h00;
    case (i_reg_addr)
      `RIO_REG_DRIVE_SEL: begin
        rdata_nxt = {5'h00, drive_sel_r};
      end
      `RIO_REG_TX_TRIG: begin
        rdata_nxt = {4'h0, tx_trig_r};
      end
      `RIO_REG_PORT_A: begin
        rdata_nxt = port_a_r;
      end
      `RIO_REG_PORT_B: begin
        rdata_nxt = port_b_r;
      end
      `RIO_REG_PORT_C: begin
        rdata_nxt = port_c_r;
      end
      `RIO_REG_PORT_D: begin
        rdata_nxt = {3'h0, port_d_r};
      end
      `RIO_REG_FLAG: begin
        rdata_nxt = {7'h00, flag_r};
      end
      `RIO_REG_STRAPS: begin
        rdata_nxt = {4'h0, page_size_r, dir_strap_r};
      end
      `RIO_REG_NODE_ID: begin
        rdata_nxt = {4'h0, node_id_r};
      end
      `RIO_REG_PIN_C: begin
        rdata_nxt = i_bidir_port_three;
      end
      `RIO_REG_PIN_D: begin
        rdata_nxt = {3'h0, i_bidir_port_four};
      end
      `RIO_REG_TRIG_STAT: begin
        rdata_nxt = {4'h0, !i_bidir_port_four[0] && trig2_en,
          !i_bidir_port_three[0] && trig1_en, trig2_en, trig1_en};
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_nxt;
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

endmodule // rio_pin_cfg
`default_nettype wire

// ---- tb/rio_field_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// field devices drive a line only where the port leaves it undriven
module rio_field_model (
  input wire [7:0] i_out3,
  input wire [7:0] i_oe3,
  input wire [7:0] i_fld3,
  output wire [7:0] o_pin3,
  input wire [4:0] i_out4,
  input wire [4:0] i_oe4,
  input wire [4:0] i_fld4,
  output wire [4:0] o_pin4
);
  assign o_pin3 = (i_out3 & i_oe3) | (i_fld3 & ~i_oe3);
  assign o_pin4 = (i_out4 & i_oe4) | (i_fld4 & ~i_oe4);
endmodule // rio_field_model
`default_nettype wire

// ---- tb/rio_pin_cfg_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); \
  end \
end
module rio_pin_cfg_bench;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, en;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, d, ex, fld3 = 8'h00;
  logic [2:0] strap = 3'h0;
  logic [4:0] fld4 = 5'h00, pid;
  wire [7:0] rdata, p1, p1oe, p2, p2oe, p3, p3oe, pin3;
  wire [4:0] p4, p4oe, pin4;
  wire [3:0] nid;
  wire t1, t2, pg;
  int fails = 0, comparisons = 0, seed = 32'hbf95;
  // strap sets; only the last one has the third strap high, making port four bit 4 the flag output
  logic [2:0] st[$] = '{3'h0, 3'h3, 3'h2, 3'h4};
  initial forever #2.5 clk = ~clk;
  rio_pin_cfg dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_direction_strap(strap),
    .o_out_port_one_lines(p1), .o_out_port_one_lines_oe(p1oe), .o_out_port_two_lines(p2),
    .o_out_port_two_lines_oe(p2oe), .i_bidir_port_three(pin3), .o_bidir_port_three(p3),
    .o_bidir_port_three_oe(p3oe), .i_bidir_port_four(pin4), .o_bidir_port_four(p4),
    .o_bidir_port_four_oe(p4oe), .o_ext_trigger_first(t1), .o_ext_trigger_second(t2),
    .o_node_id(nid), .o_page_size_strap(pg));
  rio_field_model u_fld (.i_out3(p3), .i_oe3(p3oe), .i_fld3(fld3), .o_pin3(pin3),
    .i_out4(p4), .i_oe4(p4oe), .i_fld4(fld4), .o_pin4(pin4));
  task tally_and_finish;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task wreg(input [3:0] a, input [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input [3:0] a, input [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  initial begin
    #30000;
    fails++;
    tally_and_finish;
  end
  initial begin
    foreach (st[k]) begin
      @(posedge clk);
      rst_n <= 1'b0;
      strap <= st[k];
      fld4 <= 5'($random(seed));
      fld3 <= 8'hFF;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      strap <= ~st[k];
      pid = fld4;
      #1;
      `CHK("node_id", pid[3:0], nid)
      `CHK("page", pid[4], pg)
      rreg(4'h8, {4'h0, pid[4], st[k]});
      rreg(4'h9, {4'h0, pid[3:0]});
      rreg(4'h0, 8'h07);
      rreg(4'h7, 8'h00);
      wreg(4'h2, 8'hA5);
      @(posedge clk);
      #1;
      `CHK("one_oe_default", 8'h5A, p1oe)
      for (int ds = 0; ds < 8; ds++) begin
        d = 8'($random(seed));
        wreg(4'h0, 8'(ds));
        wreg(4'h2, d);
        wreg(4'h3, ~d);
        wreg(4'h4, d);
        @(posedge clk);
        #1;
        `CHK("one_oe", ds[0] ? ~d : 8'hFF, p1oe)
        `CHK("one", ds[0] ? 8'h00 : d, p1)
        `CHK("two_oe", ds[1] ? d : 8'hFF, p2oe)
        `CHK("two", ds[1] ? 8'h00 : ~d, p2)
        ex = !st[k][0] ? 8'h00 : ds[2] ? ~d : 8'hFF;
        `CHK("three_oe", ex, p3oe)
        ex = (st[k][0] && !ds[2]) ? d : 8'h00;
        `CHK("three", ex, p3 & p3oe)
      end
      for (int tg = 0; tg < 16; tg++) begin
        wreg(4'h1, 8'(tg));
        fld3 <= 8'($random(seed));
        fld4 <= 5'($random(seed));
        repeat (2) @(posedge clk);
        en = !st[k][0] && (tg == 6 || tg == 7);
        #1;
        `CHK("trig1", en && !fld3[0], t1)
        `CHK("trig2", en && st[k][1] && !fld4[0], t2)
        ex = {4'h0, en && st[k][1] && !fld4[0], en && !fld3[0], en && st[k][1], en};
        rreg(4'hC, ex);
      end
      `CHK("four_oe", {st[k][2] | st[k][1], st[k][1] ? 4'hF : 4'h0}, p4oe)
      // port four data and the flag bit, seen only where driven
      d = 8'($random(seed));
      wreg(4'h5, d);
      wreg(4'h6, {7'h00, d[5]});
      @(posedge clk);
      #1;
      ex = {3'h0, st[k][2] ? d[5] : st[k][1] & d[4], st[k][1] ? d[3:0] : 4'h0};
      `CHK("four", ex[4:0], p4 & p4oe)
      rreg(4'h5, {3'h0, d[4:0]});
      rreg(4'h6, {7'h00, d[5]});
    end
    tally_and_finish;
  end
endmodule // rio_pin_cfg_bench
`default_nettype wire

// ---- tb/rio_pin_cfg_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module rio_pin_cfg_properties #(
  parameter PORT_W = 8,
  parameter PD_W = 5
) (
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire [3:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire [2:0] i_direction_strap,
  input wire [PORT_W-1:0] i_bidir_port_three,
  input wire [PD_W-1:0] i_bidir_port_four,
  input wire [PORT_W-1:0] o_out_port_one_lines,
  input wire [PORT_W-1:0] o_out_port_one_lines_oe,
  input wire [PORT_W-1:0] o_out_port_two_lines_oe,
  input wire [PORT_W-1:0] o_bidir_port_three_oe,
  input wire [PD_W-1:0] o_bidir_port_four_oe,
  input wire o_ext_trigger_first,
  input wire o_ext_trigger_second,
  input wire [3:0] o_node_id,
  input wire o_page_size_strap
);
  logic [1:0] cnt_r;
  logic [2:0] st_r;
  logic [PD_W-1:0] pid_r;
  logic [3:0] trg_r;
  wire live = cnt_r == 2'h3;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 2'h0;
      trg_r <= 4'h0;
    end else begin
      if (!live) begin
        cnt_r <= cnt_r + 2'h1;
      end
      if (i_reg_wr && i_reg_addr == 4'h1) begin
        trg_r <= i_reg_wdata[3:0];
      end
    end
  end
  // straps are latched until the shared pins take up their port use
  always_ff @(posedge i_clk_sys) begin
    if (!live) begin
      st_r <= i_direction_strap;
      pid_r <= i_bidir_port_four;
    end
  end
  wire ext_on = trg_r == 4'h6 || trg_r == 4'h7;
  wire trig1_exp = !st_r[0] && ext_on && !i_bidir_port_three[0];
  wire trig2_exp = !st_r[0] && st_r[1] && ext_on && !i_bidir_port_four[0];
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  sequence s_dsel_wr(int b, bit v);
    i_reg_wr && i_reg_addr == 4'h0 && i_reg_wdata[b] == v;
  endsequence
  a_one_push: assert property (s_dsel_wr(0, 0) |-> ##2 o_out_port_one_lines_oe == 8'hFF)
    else $error("port one not push-pull");
  a_one_open: assert property (s_dsel_wr(0, 1) |-> ##2 o_out_port_one_lines == 8'h00)
    else $error("port one not open-drain");
  a_two_push: assert property (s_dsel_wr(1, 0) |-> ##2 o_out_port_two_lines_oe == 8'hFF)
    else $error("port two not push-pull");
  a_three_push: assert property (s_dsel_wr(2, 0) ##0 st_r[0] |->
    ##2 o_bidir_port_three_oe == 8'hFF)
    else $error("port three not push-pull");
  a_three_input: assert property (live && !st_r[0] |->
    o_bidir_port_three_oe == 8'h00)
    else $error("port three driven as input");
  a_four_input: assert property (live && st_r[2:1] == 2'h0 |->
    o_bidir_port_four_oe == 5'h00)
    else $error("port four driven as input");
  a_flag_drive: assert property (live && st_r[2] |-> o_bidir_port_four_oe[4])
    else $error("flag bit not driven");
  a_trig_first: assert property (live |=> o_ext_trigger_first == $past(trig1_exp))
    else $error("first trigger wrong");
  a_trig_second: assert property (live |=> o_ext_trigger_second == $past(trig2_exp))
    else $error("second trigger wrong");
  a_strap_keep: assert property (live |->
    {o_page_size_strap, o_node_id} == pid_r)
    else $error("strapped id or page size wrong");
endmodule // rio_pin_cfg_properties
bind rio_pin_cfg rio_pin_cfg_properties #(.PORT_W(PORT_W), .PD_W(PD_W)) u_props (.*);
`default_nettype wire
